/* File: shared/pmt8_pkg.sv */
// Package with register map, field layout and constants of the period match timer block.
package pmt8_pkg;
    // =========================================================================
    // Register map
    // =========================================================================
    localparam int unsigned PMT8_NUM_TIMERS = 3;
    localparam logic [7:0] PMT8_STRIDE = 8'h10;
    localparam logic [7:0] PMT8_OFF_COUNT = 8'h00;
    localparam logic [7:0] PMT8_OFF_PERIOD = 8'h04;
    localparam logic [7:0] PMT8_OFF_CTRL = 8'h08;
    localparam logic [7:0] PMT8_OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] PMT8_OFF_IRQ_ENABLE = 8'h34;
    localparam logic [7:0] PMT8_OFF_IRQ_CLEAR = 8'h38;
    localparam logic [7:0] PMT8_OFF_CORE_CTRL = 8'h3c;
    // =========================================================================
    // Fields and reset values
    // =========================================================================
    localparam int unsigned PMT8_CKPS_LSB = 0;
    localparam int unsigned PMT8_ON_BIT = 2;
    localparam int unsigned PMT8_OUTPS_LSB = 3;
    localparam int unsigned PMT8_SLEEP_BIT = 0;
    localparam logic [7:0] PMT8_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT8_PERIOD_RST = 8'hff;
    localparam logic [6:0] PMT8_CTRL_RST = 7'h00;
    localparam int unsigned PMT8_INSTR_DIV = 4;
    typedef enum logic [1:0] {
        PMT8_PS_1 = 2'b00,
        PMT8_PS_4 = 2'b01,
        PMT8_PS_16 = 2'b10,
        PMT8_PS_64 = 2'b11
    } pmt8_ps_t;
    typedef struct packed {
        logic [3:0] postscale_select;
        logic timer_on_bit;
        logic [1:0] prescale_select;
    } pmt8_ctrl_t;
endpackage : pmt8_pkg

/* File: rtl/pmt8_top.sv */
// Three period match timers behind a classic Wishbone register slave.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module pmt8_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic [2:0] match_o,
    output logic shift_clk_o
);
    // =========================================================================
    // Bus decode
    // =========================================================================
    logic ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [2:0] status_r;
    logic [2:0] enable_r;
    logic sleep_r;
    logic [1:0] instr_div_r;
    logic [2:0] done_w;
    logic [7:0] cnt_w [3];
    logic [7:0] per_w [3];
    logic [6:0] ctl_w [3];
    // The ack is registered, so an access takes two cycles but read data comes from flops.
    wire req_w = wb_cyc_i & wb_stb_i & ~ack_r;
    // Every register lives in bits 7:0, so a write without the low byte lane is dropped.
    wire wr_w = req_w & wb_we_i & wb_sel_i[0];
    wire [3:0] slot_w = wb_adr_i[7:4];
    wire [3:0] reg_w = wb_adr_i[3:0];
    wire wr_stat_w = wr_w & (wb_adr_i == pmt8_pkg::PMT8_OFF_IRQ_ENABLE);
    wire wr_clr_w = wr_w & (wb_adr_i == pmt8_pkg::PMT8_OFF_IRQ_CLEAR);
    wire wr_core_w = wr_w & (wb_adr_i == pmt8_pkg::PMT8_OFF_CORE_CTRL);
    wire instr_tick_w = ce_i & ~sleep_r & (instr_div_r == 2'(pmt8_pkg::PMT8_INSTR_DIV - 1));
    // =========================================================================
    // Timer instances
    // =========================================================================
    // three identical timers
    for (genvar g = 0; g < pmt8_pkg::PMT8_NUM_TIMERS; g++) begin : g_tmr
        wire sel_w = (slot_w == 4'(g));
        pmt8_timer u_tmr (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .tick_i(instr_tick_w),
            .wr_cnt_i(wr_w & sel_w & (reg_w == pmt8_pkg::PMT8_OFF_COUNT[3:0])),
            .wr_per_i(wr_w & sel_w & (reg_w == pmt8_pkg::PMT8_OFF_PERIOD[3:0])),
            .wr_ctl_i(wr_w & sel_w & (reg_w == pmt8_pkg::PMT8_OFF_CTRL[3:0])),
            .wdata_i(wb_dat_i[7:0]),
            .count_o(cnt_w[g]),
            .period_o(per_w[g]),
            .ctrl_o(ctl_w[g]),
            .match_o(match_o[g]),
            .done_o(done_w[g])
        );
    end
    // only timer zero drives the shift clock
    assign shift_clk_o = match_o[0];
    // =========================================================================
    // Read mux and interrupt
    // =========================================================================
    // Unmapped offsets read zero, so software probing the map sees stable values.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (slot_w < 4'h3) begin
            case (reg_w)
                pmt8_pkg::PMT8_OFF_COUNT[3:0]: rdata_nxt = {24'h00_0000, cnt_w[slot_w[1:0]]};
                pmt8_pkg::PMT8_OFF_PERIOD[3:0]: rdata_nxt = {24'h00_0000, per_w[slot_w[1:0]]};
                pmt8_pkg::PMT8_OFF_CTRL[3:0]: rdata_nxt = {25'h000_0000, ctl_w[slot_w[1:0]]};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end else begin
            case (wb_adr_i)
                pmt8_pkg::PMT8_OFF_IRQ_STATUS: rdata_nxt = {29'h0, status_r};
                pmt8_pkg::PMT8_OFF_IRQ_ENABLE: rdata_nxt = {29'h0, enable_r};
                pmt8_pkg::PMT8_OFF_CORE_CTRL: rdata_nxt = {31'h0, sleep_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            status_r <= 3'h0;
            enable_r <= 3'h0;
            sleep_r <= 1'b0;
            instr_div_r <= 2'h0;
        end else if (ce_i) begin
            ack_r <= req_w;
            if (req_w) begin
                rdata_r <= rdata_nxt;
            end
            status_r <= (status_r & ~(wr_clr_w ? wb_dat_i[2:0] : 3'h0)) | done_w;
            if (wr_stat_w) begin
                enable_r <= wb_dat_i[2:0];
            end
            // sleep freezes the divider and timers
            if (wr_core_w) begin
                sleep_r <= wb_dat_i[pmt8_pkg::PMT8_SLEEP_BIT];
            end
            if (!sleep_r) begin
                instr_div_r <= instr_div_r + 2'h1;
            end
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign irq_o = |(status_r & enable_r);
    // =========================================================================
    // Assertions
    // =========================================================================
    // A request counts only while no answer is pending and the clock runs.
    sequence bus_take_s;
        wb_cyc_i && wb_stb_i && !ack_r && ce_i;
    endsequence
    // A read of the write-only clear register.
    sequence clr_read_s;
        bus_take_s ##0 (!wb_we_i && wb_adr_i == pmt8_pkg::PMT8_OFF_IRQ_CLEAR);
    endsequence
    // Ack rises one cycle after a fresh request and falls the next.
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_take_s |=> wb_ack_o) else $error("request not answered");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && ack_r) |=> !ack_r) else $error("ack held more than one cycle");
    clr_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_read_s |=> wb_dat_o == 32'h0000_0000) else $error("clear register read nonzero");
    irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_r == 3'h0) |-> !irq_o) else $error("interrupt not gated by enable");
    irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (status_r[1] && enable_r[1]) |-> irq_o) else $error("enabled flag gave no interrupt");
    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && done_w[0]) |=> status_r[0]) else $error("flag lost on event");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_clr_w && wb_dat_i[1] && !done_w[1]) |=> !status_r[1])
        else $error("flag not cleared");
    shift_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
        shift_clk_o == match_o[0]) else $error("shift clock not timer zero match");
    sleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sleep_r && !wr_w) |=> (cnt_w[1] == $past(cnt_w[1]))) else $error("count moved asleep");
    quarter_a: assert property (@(posedge clk_i) disable iff (rst_i)
        instr_tick_w |=> (!instr_tick_w) [*3]) else $error("tick faster than a quarter");
    // Clock enable low must freeze the bus answer and the divider alike.
    top_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(ack_r) && $stable(status_r) && $stable(instr_div_r))
        else $error("state moved with clock enable low");
endmodule : pmt8_top

// One eight bit period match timer with prescaler and postscaler.
module pmt8_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic wr_cnt_i,
    input wire logic wr_per_i,
    input wire logic wr_ctl_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] count_o,
    output logic [7:0] period_o,
    output logic [6:0] ctrl_o,
    output logic match_o,
    output logic done_o
);
    // =========================================================================
    // Scalers and counter
    // =========================================================================
    logic [7:0] count_r;
    logic [7:0] period_r;
    pmt8_pkg::pmt8_ctrl_t ctrl_r;
    logic [5:0] pre_r;
    logic [3:0] post_r;
    logic [5:0] pre_last_w;
    always_comb begin
        case (ctrl_r.prescale_select)
            pmt8_pkg::PMT8_PS_1: pre_last_w = 6'h00;
            pmt8_pkg::PMT8_PS_4: pre_last_w = 6'h03;
            pmt8_pkg::PMT8_PS_16: pre_last_w = 6'h0f;
            pmt8_pkg::PMT8_PS_64: pre_last_w = 6'h3f;
            default: pre_last_w = 6'h00;
        endcase
    end
    wire run_w = tick_i & ctrl_r.timer_on_bit;
    wire pre_tick_w = run_w & (pre_r == pre_last_w);
    wire equal_w = (count_r == period_r);
    // Qualifying with the prescaled tick gives one pulse per period, not one per clock.
    wire match_w = pre_tick_w & equal_w;
    // field n completes after n plus one matches
    wire post_done_w = match_w & (post_r == ctrl_r.postscale_select);
    // A restart of both scalers lets a new setting run a full first period.
    wire clr_scale_w = wr_cnt_i | wr_ctl_i;
    always_ff @(posedge clk_i) begin
        // every reset source arrives on rst_i
        if (rst_i) begin
            count_r <= pmt8_pkg::PMT8_COUNT_RST;
            period_r <= pmt8_pkg::PMT8_PERIOD_RST;
            ctrl_r <= pmt8_pkg::PMT8_CTRL_RST;
            pre_r <= 6'h00;
            post_r <= 4'h0;
        end else if (ce_i) begin
            // software access to period and control
            if (wr_per_i) begin
                period_r <= wdata_i;
            end
            if (wr_ctl_i) begin
                ctrl_r <= wdata_i[6:0];
            end
            if (clr_scale_w) begin
                pre_r <= 6'h00;
                post_r <= 4'h0;
            end else if (run_w) begin
                pre_r <= pre_tick_w ? 6'h00 : pre_r + 6'h01;
                if (match_w) begin
                    post_r <= post_done_w ? 4'h0 : post_r + 4'h1;
                end
            end
            if (wr_cnt_i) begin
                count_r <= wdata_i;
            end else if (pre_tick_w) begin
                count_r <= equal_w ? 8'h00 : count_r + 8'h01;
            end
        end
    end
    assign count_o = count_r;
    assign period_o = period_r;
    assign ctrl_o = ctrl_r;
    assign match_o = match_w;
    assign done_o = post_done_w;
    // =========================================================================
    // Assertions
    // =========================================================================
    // A match that no count write overrides.
    sequence match_s;
        ce_i && match_w && !wr_cnt_i;
    endsequence
    sequence zero_s;
        count_r == 8'h00;
    endsequence
    match_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        match_s |=> zero_s) else $error("no clear after match");
    pre_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && run_w && !pre_tick_w && !clr_scale_w) |=> pre_r == $past(pre_r) + 6'h01)
        else $error("prescaler did not step");
    post_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && match_w && !post_done_w && !clr_scale_w) |=> post_r == $past(post_r) + 4'h1)
        else $error("postscaler did not step");
    reset_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (count_r == pmt8_pkg::PMT8_COUNT_RST)
            && (period_r == pmt8_pkg::PMT8_PERIOD_RST)) else $error("reset values wrong");
    ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(count_r) && $stable(pre_r) && $stable(post_r))
        else $error("timer moved with clock enable low");
    count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && pre_tick_w && !equal_w && !wr_cnt_i) |=> count_r == $past(count_r) + 8'h01)
        else $error("count did not step");
    off_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl_r.timer_on_bit && !wr_cnt_i && !wr_ctl_i) |=> $stable(count_r) && $stable(pre_r))
        else $error("timer moved while off");
    scale_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && clr_scale_w) |=> pre_r == 6'h00 && post_r == 4'h0)
        else $error("scalers not cleared on write");
    no_match_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_r.timer_on_bit |-> !match_o) else $error("match while off");
endmodule : pmt8_timer

/* File: verification/test_pmt8_top.sv */
// Self-checking bench for the three period match timers behind their register slave.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_pmt8_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [3:0] nsel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic irq;
    logic shift_clk;
    logic [2:0] match;
    int n_errors = 0;
    int tests_run = 0;
    int mdl_per[3];
    pmt8_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .match_o(match), .shift_clk_o(shift_clk));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // =========================================================================
    // Bus and check tasks
    // =========================================================================
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= nsel;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        if (t >= 20) n_errors++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask : rdc
    // A match is a one-cycle pulse, so it is sampled at every edge.
    task automatic wait_match(input int g, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (match[g] !== 1'b1 && n < 2000);
        `CHK("shift clock", match[0], shift_clk)
    endtask : wait_match
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        int n;
        int m;
        logic [31:0] v;
        void'($urandom(40));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int g = 0; g < 3; g++) begin
            rdc("count", 8'(g * 16), 32'h0);
            rdc("period", 8'(g * 16 + 4), 32'hff);
            rdc("control", 8'(g * 16 + 8), 32'h0);
            v = 32'($urandom_range(255));
            mdl_per[g] = int'(v);
            bus(1'b1, 8'(g * 16 + 4), v);
            rdc("period", 8'(g * 16 + 4), 32'(mdl_per[g]));
            bus(1'b1, 8'(g * 16), v ^ 32'hff);
            rdc("count", 8'(g * 16), v ^ 32'hff);
        end
        rdc("unmapped", 8'h20 + 8'h0c, 32'h0);
        nsel = 4'he;
        bus(1'b1, 8'h04, 32'h0);
        nsel = 4'hf;
        rdc("period", 8'h04, 32'(mdl_per[0]));
        $display("test registers done");
        // Each match interval is (period + 1) prescaled ticks, each the prescale times four clocks.
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'h04, 32'h2);
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b1, 8'h08, 32'(4 | k));
            wait_match(0, n);
            wait_match(0, n);
            `CHK("match interval", 3 * (1 << (2 * k)) * 4, n)
        end
        bus(1'b1, 8'h08, 32'h0);
        $display("test prescale done");
        bus(1'b1, 8'h14, 32'h1);
        bus(1'b1, 8'h34, 32'h2);
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 15 : int'($urandom_range(14, 1));
            bus(1'b1, 8'h18, 32'h0);
            bus(1'b1, 8'h38, 32'h7);
            bus(1'b1, 8'h10, 32'h0);
            bus(1'b1, 8'h18, 32'((n << 3) | 4));
            m = 0;
            for (int c = 0; c < 400 && irq !== 1'b1; c++) begin
                @(posedge clk_i);
                if (match[1] === 1'b1) m++;
            end
            `CHK("matches per flag", n + 1, m)
        end
        bus(1'b1, 8'h18, 32'h0);
        bus(1'b1, 8'h34, 32'h0);
        `CHK("masked irq", 1'b0, irq)
        rdc("status", 8'h30, 32'h2);
        bus(1'b1, 8'h38, 32'h2);
        rdc("status", 8'h30, 32'h0);
        rdc("clear reg", 8'h38, 32'h0);
        $display("test postscale done");
        bus(1'b1, 8'h24, 32'hff);
        bus(1'b1, 8'h20, 32'h0);
        bus(1'b1, 8'h28, 32'h4);
        bus(1'b1, 8'h3c, 32'h1);
        bus(1'b0, 8'h20, 32'h0);
        v = q;
        repeat (40) @(posedge clk_i);
        rdc("count in sleep", 8'h20, v);
        rdc("period in sleep", 8'h24, 32'hff);
        bus(1'b1, 8'h3c, 32'h0);
        repeat (40) @(posedge clk_i);
        bus(1'b0, 8'h20, 32'h0);
        `CHK("count running", 1'b1, q > v)
        bus(1'b1, 8'h28, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        v = q;
        repeat (40) @(posedge clk_i);
        rdc("count when off", 8'h20, v);
        $display("test sleep and off done");
        // Four running edges lie between the two reads, so exactly one tick.
        bus(1'b1, 8'h28, 32'h4);
        bus(1'b0, 8'h20, 32'h0);
        v = q;
        @(posedge clk_i);
        ce <= 1'b0;
        repeat (40) @(posedge clk_i);
        ce <= 1'b1;
        bus(1'b0, 8'h20, 32'h0);
        `CHK("count frozen", 32'h1, q - v)
        bus(1'b1, 8'h28, 32'h0);
        $display("test clock enable done");
        bus(1'b1, 8'h04, 32'h33);
        bus(1'b1, 8'h08, 32'h7c);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("count after reset", 8'h00, 32'h0);
        rdc("period after reset", 8'h04, 32'hff);
        rdc("control after reset", 8'h08, 32'h0);
        `CHK("irq after reset", 1'b0, irq)
        $display("test reset done");
        tally_and_finish();
    end
endmodule : test_pmt8_top
